// ---- hw/flash_command_sequencer.sv ----
`timescale 1ns/10ps
// How it works
// - An erased page takes one page program; reprogramming needs an erase first.
// - Never program a word inside a block whose protection flag is set.
// - Page program: three unlock cycles ending 0xA0, then page words ascending.
// - Chip erase skips protected blocks; all protected means straight back to read.
// - Chip erase is AA,55,80,AA,55,10; erase starts after the sixth cycle.
// - Block erase: five unlock cycles then 0x30 in the block; protected is skipped.
// - Protect set: AA,55,9A,AA,55,9A then 9A at selector; sets one flag.
// - Protect clear: AA,55,6A,AA,55,6A then 6A starts the flag erase.
// - Without security the four protection flags clear together, never singly.
// - With security, flag clear first erases the whole array, then the flags.
// - Done flag reads zero while an operation runs, one again after, read mode.
// - Only hardware reset aborts a running operation, never a command.
// - Code read: AA,55,90 then 0x00 at selector; flash reads return the code.
// - Code read mode stays, accepting repeated selector writes and reads.
// - Code read mode is left only by read, read/reset, hardware reset or an accepted program, erase or protect command.
// - Read is one 0xF0 write; read/reset is AA,55,F0; both give read mode.
// - Read or read/reset in mid sequence, outside page data, cancels it and returns to read mode.
// - Command cycles are word writes; only the low data byte is decoded.
// - Unlock cycles alternate command addresses 0x55 and 0xAA in the address field.
// - Cycles out of the defined order abandon the sequence to read mode, or to code read mode if it began there.
// - New command sequences are ignored while an operation runs.
// - Hardware reset stops a running operation and gives read mode.
module flash_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h11, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h22, // Arbitrary value
    parameter logic [7:0] MACRO_CODE = 8'h44 // Arbitrary value
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire bus_req_s bus,
    output logic [DATA_W-1:0] rdata,
    input wire logic [DATA_W-1:0] array_rdata,
    output arr_cmd_s arr_cmd,
    output logic operation_done_flag
);
    // Whole sequencer state lives in one register
    typedef struct packed {
        state_e st;
        act_e act;
        logic [7:0] code;
        logic id;
        logic [1:0] idsel;
        logic [1:0] psel;
        logic [ADDR_W-1:0] base;
        logic [CNT_W-1:0] cnt;
        logic [NBLK-1:0] prot;
        logic sec;
        logic [DATA_W-1:0] rdata;
        arr_cmd_s arr;
    } seq_s;

    seq_s q;
    seq_s n;
    logic is_flash;
    logic is_reg;
    logic wr_cmd;
    logic pg_ok;
    logic [7:0] ca;
    logic [7:0] dat;
    logic t_start;
    logic t_done;
    logic t_busy;
    logic [TMR_W-1:0] t_cycles;

    // Command address field of a bus address
    function automatic logic [7:0] cmd_addr(input logic [ADDR_W-1:0] a);
        return a[CADDR_LSB +: 8];
    endfunction : cmd_addr

    // Block index of a flash address
    function automatic logic [1:0] blk_of(input logic [ADDR_W-1:0] a);
        return a[BLK_LSB +: 2];
    endfunction : blk_of

    // Identification code by selector; selector 2 is reserved
    function automatic logic [7:0] code_of(input logic [1:0] sel);
        case (sel)
            2'h0: return MAKER_CODE;
            2'h1: return DEVICE_CODE;
            2'h3: return MACRO_CODE;
            default: return 8'h00;
        endcase
    endfunction : code_of

    // Bus decode; only the low data byte carries a command
    assign is_flash = bus.addr[ADDR_W-1 -: 2] == AREA_FLASH;
    assign is_reg = bus.addr[ADDR_W-1 -: 2] == AREA_REG;
    assign ca = cmd_addr(bus.addr);
    assign dat = bus.wdata[7:0];
    assign wr_cmd = bus.wr && is_flash && (q.st != S_BUSY);
    assign pg_ok = bus.addr == q.base + {{(ADDR_W-CNT_W-2){1'b0}}, q.cnt, 2'b00};

    // Next state of the sequencer, read path and array strobes
    always_comb begin
        n = q;
        n.arr.prog = 1'b0;
        n.arr.erase = '0;
        n.rdata = '0;
        t_start = 1'b0;
        t_cycles = PROG_CYCLES;

        // Read data stand only in the cycle after the strobe
        if (bus.rd) begin
            if (is_reg) begin
                case (bus.addr)
                    OFS_STATUS: begin
                        n.rdata[ST_DONE] = q.st != S_BUSY;
                        n.rdata[ST_SEC] = q.sec;
                    end
                    OFS_PROT: n.rdata[NBLK-1:0] = q.prot;
                    OFS_CTRL: n.rdata[CTRL_SEC] = q.sec;
                    default: n.rdata = '0;
                endcase
            end else if (is_flash && q.st == S_ID) begin
                n.rdata[7:0] = code_of(q.idsel);
            end else if (is_flash && q.st != S_BUSY) begin
                n.rdata = array_rdata;
            end
        end

        // Security control from software
        if (bus.wr && is_reg && bus.addr == OFS_CTRL) begin
            n.sec = bus.wdata[CTRL_SEC];
        end

        // Completion: apply flag change, back to read mode
        if (q.st == S_BUSY && t_done) begin
            case (q.act)
                ACT_PSET: n.prot[q.psel] = 1'b1;
                ACT_PCLR: n.prot = '0;
                default: n.prot = q.prot;
            endcase
            n.act = ACT_NONE;
            n.st = S_READ;
            n.id = 1'b0;
        end

        // Command cycles; page data may hold 0xF0 so it is not a reset there
        if (wr_cmd) begin
            if (dat == CMD_RESET && q.st != S_PAGE && q.st != S_PG1) begin
                n.st = S_READ;
                n.id = 1'b0;
            end else begin
                // Anything unexpected falls back to the resting mode
                n.st = q.id ? S_ID : S_READ;
                case (q.st)
                    S_READ, S_ID: begin
                        if (ca == ADR_55 && dat == UNLOCK1) begin
                            n.st = S_C1;
                        end else if (q.st == S_ID && dat == CMD_IDSEL) begin
                            n.idsel = bus.addr[IDSEL_LSB +: 2];
                        end
                    end
                    S_C1: begin
                        if (ca == ADR_AA && dat == UNLOCK2) begin
                            n.st = S_C2;
                        end
                    end
                    S_C2: begin
                        if (ca == ADR_55) begin
                            case (dat)
                                CMD_ID: begin
                                    n.st = S_ID;
                                    n.id = 1'b1;
                                end
                                CMD_PROG: n.st = S_PG1;
                                CMD_ERASE, CMD_PSET, CMD_PCLR: begin
                                    n.st = S_X3;
                                    n.code = dat;
                                end
                                default: n.st = q.id ? S_ID : S_READ;
                            endcase
                        end
                    end
                    S_X3: begin
                        if (ca == ADR_55 && dat == UNLOCK1) begin
                            n.st = S_X4;
                        end
                    end
                    S_X4: begin
                        if (ca == ADR_AA && dat == UNLOCK2) begin
                            n.st = S_X5;
                        end
                    end
                    S_X5: begin
                        if (q.code == CMD_ERASE && ca == ADR_55 && dat == CMD_CHIP) begin
                            // All blocks locked: nothing to erase, read mode at once
                            n.st = S_READ;
                            n.id = 1'b0;
                            if (q.prot != '1) begin
                                n.arr.erase = ~q.prot;
                                n.st = S_BUSY;
                                t_start = 1'b1;
                                t_cycles = ERASE_CYCLES;
                            end
                        end else if (q.code == CMD_ERASE && dat == CMD_BLOCK) begin
                            n.st = S_READ;
                            n.id = 1'b0;
                            if (!q.prot[blk_of(bus.addr)]) begin
                                n.arr.erase[blk_of(bus.addr)] = 1'b1;
                                n.st = S_BUSY;
                                t_start = 1'b1;
                                t_cycles = ERASE_CYCLES;
                            end
                        end else if (q.code != CMD_ERASE && ca == ADR_55 && dat == q.code) begin
                            n.st = S_X6;
                        end
                    end
                    S_X6: begin
                        if (dat == q.code) begin
                            n.st = S_BUSY;
                            t_start = 1'b1;
                            if (q.code == CMD_PSET) begin
                                n.act = ACT_PSET;
                                n.psel = bus.addr[PBSEL_LSB +: 2];
                            end else begin
                                n.act = ACT_PCLR;
                                if (q.sec) begin
                                    // Secured part: wipe the array before the flags
                                    n.arr.erase = '1;
                                    t_cycles = ERASE_CYCLES;
                                end
                            end
                        end
                    end
                    S_PG1: begin
                        // First word must be the page start; a misaligned one aborts
                        if (bus.addr[PAGE_LSB-1:0] == '0) begin
                            n.base = bus.addr;
                            n.cnt = CNT_W'(1);
                            n.st = S_PAGE;
                            if (!q.prot[blk_of(bus.addr)]) begin
                                n.arr.prog = 1'b1;
                                n.arr.addr = bus.addr;
                                n.arr.data = bus.wdata;
                            end
                        end
                    end
                    S_PAGE: begin
                        if (pg_ok) begin
                            if (!q.prot[blk_of(bus.addr)]) begin
                                n.arr.prog = 1'b1;
                                n.arr.addr = bus.addr;
                                n.arr.data = bus.wdata;
                            end
                            if (q.cnt == CNT_W'(PAGE_WORDS - 1)) begin
                                n.st = S_BUSY;
                                t_start = 1'b1;
                            end else begin
                                n.cnt = q.cnt + 1'b1;
                                n.st = S_PAGE;
                            end
                        end
                    end
                    default: n.st = S_READ;
                endcase
            end
        end
    end

    // Reset drops any running operation; flags are not kept across it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Array operation time
    op_timer u_tmr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(t_start),
        .cycles(t_cycles),
        .busy(t_busy),
        .done(t_done)
    );

    assign rdata = q.rdata;
    assign arr_cmd = q.arr;
    assign operation_done_flag = q.st != S_BUSY;

    // Checks run on the system clock and sleep while reset is high
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_no_prot_prog: assert property (
        arr_cmd.prog |-> !q.prot[blk_of(arr_cmd.addr)])
        else $error("program strobe inside protected block");

    a_busy_holds: assert property (
        (q.st == S_BUSY && !t_done) |=> (q.st == S_BUSY && !operation_done_flag))
        else $error("running operation left without completion");

    a_done_returns: assert property (
        (q.st == S_BUSY && t_done) |=> (operation_done_flag && q.st == S_READ))
        else $error("completion did not restore read mode");

    a_chip_erase: assert property (
        (wr_cmd && q.st == S_X5 && q.code == CMD_ERASE && ca == ADR_55 && dat == CMD_CHIP)
        |=> (arr_cmd.erase == ~$past(q.prot)) && (operation_done_flag == ($past(q.prot) == '1)))
        else $error("chip erase mask or busy state wrong");

    a_erase_skip: assert property (
        (arr_cmd.erase != '0 && q.act != ACT_PCLR) |-> ((arr_cmd.erase & q.prot) == '0))
        else $error("erase strobe hit protected block");

    a_one_flag_set: assert property (
        $countones(q.prot & ~$past(q.prot)) <= 1)
        else $error("more than one protection flag set");

    a_flags_group: assert property (
        (($past(q.prot) & ~q.prot) != '0) |-> (q.prot == '0))
        else $error("protection flags cleared singly");

    a_sw_reset: assert property (
        (wr_cmd && dat == CMD_RESET && q.st != S_PAGE && q.st != S_PG1)
        |=> (q.st == S_READ && !q.id))
        else $error("software reset did not give read mode");

    a_bad_order: assert property (
        (wr_cmd && q.st == S_C1 && !(ca == ADR_AA && dat == UNLOCK2))
        |=> (q.st == S_READ || q.st == S_ID))
        else $error("out of order cycle did not abandon sequence");

    a_id_code: assert property (
        (bus.rd && is_flash && q.st == S_ID) |=> (rdata == {24'h000000, code_of($past(q.idsel))}))
        else $error("code read returned wrong value");

    a_id_stays: assert property (
        (q.st == S_ID && !(bus.wr && is_flash && dat == CMD_RESET)) |=> q.id)
        else $error("code read mode left on its own");

    a_page_end: assert property (
        (wr_cmd && q.st == S_PAGE && pg_ok && q.cnt == CNT_W'(PAGE_WORDS - 1))
        |=> (q.st == S_BUSY) ##1 !operation_done_flag)
        else $error("page program did not start after last word");

    // A running array timer must never be seen with the done flag high;
    // catches a timer started without the busy state that owns it
    a_timer_busy: assert property (
        t_busy |-> (q.st == S_BUSY && !operation_done_flag))
        else $error("array timer running outside busy state");
endmodule : flash_command_sequencer

// ---- shared/flash_seq_pkg.sv ----
package flash_seq_pkg;
    // Bus and array widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NBLK = 4;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_WORDS = 1 << (PAGE_LSB - 2);
    localparam int CNT_W = 6;
    localparam int TMR_W = 16;

    // Command codes carried in the low data byte
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] UNLOCK1 = 8'hAA;
    localparam logic [7:0] UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_BLOCK = 8'h30;
    localparam logic [7:0] CMD_PSET = 8'h9A;
    localparam logic [7:0] CMD_PCLR = 8'h6A;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_IDSEL = 8'h00;

    // Command address field values
    localparam logic [7:0] ADR_55 = 8'h55;
    localparam logic [7:0] ADR_AA = 8'hAA;

    // Address field positions
    localparam int CADDR_LSB = 4;
    localparam int BLK_LSB = 15;
    localparam int IDSEL_LSB = 12;
    localparam int PBSEL_LSB = 7;
    localparam logic [1:0] AREA_FLASH = 2'h0;
    localparam logic [1:0] AREA_REG = 2'h1;

    // Register map and fields
    localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h4000_0000;
    localparam logic [ADDR_W-1:0] OFS_PROT = 32'h4000_0004;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h4000_0008;
    localparam int ST_DONE = 0;
    localparam int ST_SEC = 1;
    localparam int CTRL_SEC = 0;

    // Array operation times
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 1600;
    localparam int ERASE_TIME_NS = 6400;
    localparam logic [TMR_W-1:0] PROG_CYCLES = TMR_W'(PROG_TIME_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] ERASE_CYCLES = TMR_W'(ERASE_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        S_READ, S_C1, S_C2, S_ID, S_X3, S_X4, S_X5, S_X6, S_PG1, S_PAGE, S_BUSY
    } state_e;

    typedef enum logic [1:0] {ACT_NONE, ACT_PSET, ACT_PCLR} act_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic prog;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [NBLK-1:0] erase;
    } arr_cmd_s;
endpackage : flash_seq_pkg

// ---- hw/op_timer.sv ----
`timescale 1ns/10ps
module op_timer
    import flash_seq_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [TMR_W-1:0] cycles,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic run;
        logic done;
    } tmr_s;

    tmr_s q;
    tmr_s n;

    // Count down; a start while running is ignored
    always_comb begin
        n = q;
        n.done = 1'b0;
        if (q.run) begin
            if (q.cnt <= TMR_W'(1)) begin
                n.run = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = q.cnt - 1'b1;
            end
        end else if (start) begin
            n.cnt = cycles;
            n.run = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign busy = q.run;
    assign done = q.done;
endmodule : op_timer

// ---- test/flash_array_model.sv ----
`timescale 1ns/10ps
module flash_array_model
    import flash_seq_pkg::*;
(
    input wire logic core_clk,
    input wire arr_cmd_s arr_cmd,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] array_rdata
);
    logic [DATA_W-1:0] mem [0:32767];

    // Fresh array is erased, all ones
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 32'hFFFF_FFFF;
        end
    end

    // Program only pulls ones to zero, so a second program cannot restore ones
    always @(posedge core_clk) begin
        if (arr_cmd.prog) begin
            mem[arr_cmd.addr[16:2]] = mem[arr_cmd.addr[16:2]] & arr_cmd.data;
        end
        for (int b = 0; b < NBLK; b++) begin
            if (arr_cmd.erase[b]) begin
                for (int i = 0; i < 8192; i++) begin
                    mem[b * 8192 + i] = 32'hFFFF_FFFF;
                end
            end
        end
    end

    // Outside the array a changing pattern, never a stale word
    assign array_rdata = (rd_addr[31:17] == 15'h0) ? mem[rd_addr[16:2]] : ~rd_addr;
endmodule : flash_array_model

// ---- test/tb_flash_command_sequencer.sv ----
`timescale 1ns/10ps
module tb_flash_command_sequencer;
    import flash_seq_pkg::*;
    localparam logic [7:0] MK = 8'h21; // Arbitrary value
    localparam logic [7:0] DV = 8'h42; // Arbitrary value
    localparam logic [7:0] MC = 8'h63; // Arbitrary value
    localparam logic [31:0] S1 = 32'h5A00_C300;
    localparam logic [31:0] S2 = 32'h0F0F_0000;
    logic core_clk, sys_rst, done_flag;
    bus_req_s bus;
    logic [DATA_W-1:0] rdata, array_rdata;
    arr_cmd_s arr_cmd;
    int n_mismatch, n_tests;

    flash_command_sequencer #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .MACRO_CODE(MC))
        flash_command_sequencer_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .array_rdata(array_rdata), .arr_cmd(arr_cmd),
        .operation_done_flag(done_flag));
    flash_array_model flash_array_model_i (.core_clk(core_clk), .arr_cmd(arr_cmd),
        .rd_addr(bus.addr), .array_rdata(array_rdata));

    // Free running system clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One write cycle; strobe dropped on the following edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        check(rdata, exp);
    endtask : chk_rd

    task automatic chk_done(input logic exp);
        @(negedge core_clk);
        check({31'h0, done_flag}, {31'h0, exp});
    endtask : chk_done

    task automatic unlock(input logic [7:0] c);
        wr(32'h550, {24'h0, UNLOCK1});
        wr(32'hAA0, {24'h0, UNLOCK2});
        wr(32'h550, {24'h0, c});
    endtask : unlock

    // Bounded wait for the end of an automatic operation
    task automatic wait_done();
        int i;
        // The flag still shows its old value in the step of the last write
        @(negedge core_clk);
        for (i = 0; i < 300 && done_flag !== 1'b1; i++) @(negedge core_clk);
        if (i == 300) begin
            n_mismatch++;
            $display("ERROR %0t: operation never finished", $time);
            stop_test();
        end
    endtask : wait_done

    // Word 5 stays unwritten, padded with all ones by the host
    function automatic logic [31:0] word(input logic [31:0] s, input int i);
        return (i == 5) ? 32'hFFFF_FFFF : s ^ 32'(i);
    endfunction : word

    task automatic prog_page(input logic [ADDR_W-1:0] base, input logic [31:0] s);
        unlock(CMD_PROG);
        for (int i = 0; i < PAGE_WORDS; i++) wr(base + 32'(4 * i), word(s, i));
    endtask : prog_page

    // Host read-back after program, since the device does not verify
    task automatic chk_page(input logic [ADDR_W-1:0] base, input logic [31:0] s, input bit ok);
        for (int i = 0; i < PAGE_WORDS; i++) begin
            chk_rd(base + 32'(4 * i), ok ? word(s, i) : 32'hFFFF_FFFF);
        end
    endtask : chk_page

    task automatic blk_erase(input logic [ADDR_W-1:0] a);
        unlock(CMD_ERASE);
        wr(32'h550, {24'h0, UNLOCK1});
        wr(32'hAA0, {24'h0, UNLOCK2});
        wr(a, {24'h0, CMD_BLOCK});
    endtask : blk_erase

    task automatic prot_set(input int b);
        unlock(CMD_PSET);
        unlock(CMD_PSET);
        wr(32'(b) << PBSEL_LSB, {24'h0, CMD_PSET});
        wait_done();
    endtask : prot_set

    task automatic prot_clr();
        unlock(CMD_PCLR);
        unlock(CMD_PCLR);
        wr(32'h0, {24'h0, CMD_PCLR});
    endtask : prot_clr

    initial begin
        logic [7:0] codes [4];
        codes = '{MK, DV, 8'h00, MC};
        n_mismatch = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        bus = '0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_rd(OFS_STATUS, 32'h1);
        chk_rd(OFS_PROT, 32'h0);
        chk_rd(32'h4000_0010, 32'h0);
        $display("reset test done");
        // Code read with junk in the upper data bits of the first cycle
        wr(32'h550, 32'h7700_00AA);
        wr(32'hAA0, {24'h0, UNLOCK2});
        wr(32'h550, {24'h0, CMD_ID});
        for (int s = 0; s < 4; s++) begin
            wr(32'(s) << IDSEL_LSB, {24'h0, CMD_IDSEL});
            chk_rd(32'h9000, {24'h0, codes[s]});
        end
        wr(32'h550, 32'h12);
        chk_rd(32'h0, {24'h0, MC});
        wr(32'h0, {24'h0, CMD_RESET});
        chk_rd(32'h0, 32'hFFFF_FFFF);
        unlock(CMD_ID);
        wr(32'h1000, 32'h0);
        unlock(CMD_RESET);
        chk_rd(32'h0, 32'hFFFF_FFFF);
        $display("code read test done");
        prog_page(32'h8000, S1);
        chk_done(1'b0);
        chk_rd(32'h8000, 32'h0);
        wr(32'h0, {24'h0, CMD_RESET});
        chk_done(1'b0);
        wait_done();
        chk_page(32'h8000, S1, 1'b1);
        prog_page(32'h0, S2);
        wait_done();
        $display("program test done");
        prot_set(1);
        chk_rd(OFS_PROT, 32'h2);
        prog_page(32'h8080, S2);
        wait_done();
        chk_page(32'h8080, S2, 1'b0);
        blk_erase(32'h8040);
        chk_done(1'b1);
        chk_rd(32'h8000, word(S1, 0));
        unlock(CMD_ERASE);
        unlock(CMD_CHIP);
        chk_done(1'b0);
        wait_done();
        chk_rd(32'h4, 32'hFFFF_FFFF);
        chk_rd(32'h8004, word(S1, 1));
        $display("protect test done");
        unlock(CMD_ERASE);
        wr(32'h550, {24'h0, UNLOCK1});
        wr(32'h0, {24'h0, CMD_RESET});
        wr(32'hAA0, {24'h0, UNLOCK2});
        wr(32'h550, {24'h0, CMD_CHIP});
        chk_done(1'b1);
        wr(32'h550, {24'h0, UNLOCK1});
        wr(32'h550, {24'h0, UNLOCK2});
        wr(32'h550, {24'h0, CMD_PROG});
        wr(32'h100, 32'h0);
        chk_done(1'b1);
        chk_rd(32'h100, 32'hFFFF_FFFF);
        $display("abort test done");
        prot_clr();
        wait_done();
        chk_rd(OFS_PROT, 32'h0);
        chk_rd(32'h8008, word(S1, 2));
        for (int b = 0; b < NBLK; b++) prot_set(b);
        chk_rd(OFS_PROT, 32'hF);
        unlock(CMD_ERASE);
        unlock(CMD_CHIP);
        chk_done(1'b1);
        chk_rd(32'h800C, word(S1, 3));
        wr(OFS_CTRL, 32'h1);
        chk_rd(OFS_STATUS, 32'h3);
        prot_clr();
        wait_done();
        chk_rd(OFS_PROT, 32'h0);
        chk_rd(32'h8000, 32'hFFFF_FFFF);
        $display("protect clear test done");
        prog_page(32'h0, S1);
        chk_done(1'b0);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_done(1'b1);
        chk_rd(OFS_STATUS, 32'h1);
        $display("hardware reset test done");
        stop_test();
    end
endmodule : tb_flash_command_sequencer
